/* rtl/hrt_cfg.svh */
// Offsets, field positions, reset values and fixed-point constants
`ifndef HRT_CFG_SVH
`define HRT_CFG_SVH

// ****************************************************************
// Register port
// ****************************************************************
`define HRT_ADDR_W       8
`define HRT_OFS_CTRL     8'h00
`define HRT_OFS_CFG      8'h04
`define HRT_OFS_MAX_PEAK_OUTPUT     8'h08
`define HRT_OFS_STATUS   8'h0C
`define HRT_OFS_ATTEN    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define HRT_CTRL_LIMTYPE 0
`define HRT_CTRL_RPTEN   1
`define HRT_CTRL_TDM     2
`define HRT_CTRL_ENABLE  3
`define HRT_CFG_LIMTHR   0
`define HRT_CFG_ROT      8
`define HRT_CFG_MAXATN   16
`define HRT_CFG_HR       24
`define HRT_ST_BEGIN     0
`define HRT_ST_END       1
`define HRT_ST_ACTIVE    2
`define HRT_ATN_RPT      16

// ****************************************************************
// Reset values
// ****************************************************************
`define HRT_RST_MAX_PEAK_OUTPUT     16'h353E
`define HRT_RST_MAXATN   4'h5
`define HRT_RST_HR       5'h08

// ****************************************************************
// Fixed-point constants (levels in 1/64 dB)
// ****************************************************************
`define HRT_DB_UNIT      64
`define HRT_LOG_DB_K     385
`define HRT_DB_LOG_K     170
`define HRT_HR_BASE      32
`define HRT_HR_MAX_CODE  16
`define HRT_HR_DIV_K     1638
`define HRT_MAXATN_CODE  14
`define HRT_GAIN_ONE     16384
`define HRT_GAIN_FRAC    14
`define HRT_RPT_W        14
`define HRT_RPT_MAX      16383

`endif

/* rtl/hrt_pkg.sv */
// Shared types of the headroom tracking gain limiter
package hrt_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01
  } act_state_e;

  typedef logic [15:0] atten_t;

endpackage

/* rtl/hrt_gain_stage.sv */
// Applies a Q1.14 gain to each audio sample
`timescale 1ns/10ps
module hrt_gain_stage #(
  parameter int SAMPLE_W = 24
)(
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       resetn_i,
  // Sample in
  input  wire logic signed [SAMPLE_W-1:0] sample_i,
  input  wire logic                       sample_valid_i,
  input  wire logic [14:0]                gain_i,
  // Sample out
  output logic signed [SAMPLE_W-1:0]      sample_o,
  output logic                            sample_valid_o
);

  logic signed [SAMPLE_W+15:0] prod;

  // Gain never above one, so the shifted product always fits
  assign prod = sample_i * $signed({1'b0, gain_i});

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      sample_o       <= '0;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i)
        sample_o <= prod[SAMPLE_W+13:14];
    end
  end

endmodule

/* rtl/headroom_tracking_gain_limiter.sv */
// Supply-tracking limiter, compressor and gain stage for the audio path
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
`include "hrt_cfg.svh"

// Overview of operation
// R1: Level limiter caps output at limiter voltage above fixed threshold.
// R2: Level limiter curve does not depend on supply level.
// R3: Below limiter voltage, fixed knee still limits signals digitally.
// R4: Compressor rotation point programmable from 0 down to -15 dBFS.
// R5: Compressor voltage threshold is max peak output scaled by rotation.
// R6: Software picks compressor-only via rotation, level type, 0 dBFS threshold.
// R7: Inputs below rotation point pass uncompressed.
// R8: Compressor ratio follows target peak output, rising as it falls.
// R9: Software keeps compressor threshold above highest low-rail voltage.
// R10: Software picks combined mode with both points below 0 dBFS.
// R11: Software sets limiter voltage above compressor voltage threshold.
// R12: Combined mode compresses first, then hard-limits.
// R13: Begin flag when attenuation first starts.
// R14: End flag when attenuation fully released.
// R15: No flag while attenuation merely changes.
// R16: Maximum attenuation programmable -1 to -15 dB in 1 dB steps.
// R17: Attenuation clamps at the programmed maximum.
// R18: TDM report carries present attenuation as 14-bit unsigned value.
// R19: Target peak output is supply scaled by headroom, +20% to -20%.
// R20: Never positive gain; target attenuation floors at 0 dB.
// R21: Distortion limiter threshold tracks target peak output.
// R22: Level limiter threshold fixed, 0 to -15 dBFS, infinite ratio.
// R23: Attenuation applied as digital gain on every sample.
module headroom_tracking_gain_limiter
  import hrt_pkg::*;
#(
  parameter int SAMPLE_W  = 24,
  parameter int SUP_W     = 16,
  parameter int RLS_SHIFT = 10
)(
  // Clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         resetn_i,
  // Register port
  input  wire logic [`HRT_ADDR_W-1:0]       reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic [31:0]                       reg_rdata_o,
  // Supply measurement, active rail in mV
  input  wire logic [SUP_W-1:0]             supply_mv_i,
  input  wire logic                         supply_valid_i,
  // Audio path
  input  wire logic signed [SAMPLE_W-1:0]   sample_i,
  input  wire logic                         sample_valid_i,
  output logic signed [SAMPLE_W-1:0]        sample_o,
  output logic                              sample_valid_o,
  // Activity flags
  output logic                              attenuation_begin_irq_o,
  output logic                              attenuation_end_irq_o,
  // Attenuation report for the TDM output slot
  output logic [`HRT_RPT_W-1:0]             report_data_o,
  output logic                              report_valid_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (SAMPLE_W < 8 || SAMPLE_W > 31)
    $error("SAMPLE_W must lie in 8..31");
  if (SUP_W < 4 || SUP_W > 16)
    $error("SUP_W must lie in 4..16");
  if (RLS_SHIFT < 1 || RLS_SHIFT > 20)
    $error("RLS_SHIFT must lie in 1..20");

  localparam int FS_L2Q6 = (SAMPLE_W - 1) * `HRT_DB_UNIT;
  localparam int RECIP[16] = '{0, 1024, 512, 341, 256, 205, 171, 146,
                               128, 114, 102, 93, 85, 79, 73, 68};

  // Log2 in Q6 with a linear mantissa
  function automatic int log2_q6(input logic [31:0] x);
    int          p;
    logic [31:0] m;
    p = 0;
    for (int i = 0; i < 32; i++)
    begin
      if (x[i])
        p = i;
    end
    if (p >= 6)
      m = x >> (p - 6);
    else
      m = x << (6 - p);
    return p * `HRT_DB_UNIT + int'(m[5:0]);
  endfunction

  // Difference of two Q6 logs to 1/64 dB
  function automatic int l2_to_db(input int d);
    return (d * `HRT_LOG_DB_K) >>> 6;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic        lim_type_q;
  logic        rpt_en_q;
  logic        tdm_q;
  logic        enable_q;
  logic [3:0]  lim_thr_q;
  logic [3:0]  rot_q;
  logic [3:0]  max_sel_q;
  logic [4:0]  hr_q;
  logic [15:0] max_peak_output_q;
  logic [15:0] vsup_q;
  logic        begin_flag_q;
  logic        end_flag_q;
  act_state_e  act_q;
  atten_t      att_q;
  atten_t      att_d;
  logic [14:0] gain_q;
  logic [14:0] gain_d;
  logic [SAMPLE_W-1:0] peak_q;

  logic        wr_status;

  assign wr_status = reg_wr_i && (reg_addr_i == `HRT_OFS_STATUS);

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      lim_type_q <= 1'b0;
      rpt_en_q   <= 1'b0;
      tdm_q      <= 1'b0;
      enable_q   <= 1'b0;
      lim_thr_q  <= '0;
      rot_q      <= '0;
      max_sel_q  <= `HRT_RST_MAXATN;
      hr_q       <= `HRT_RST_HR;
      max_peak_output_q     <= `HRT_RST_MAX_PEAK_OUTPUT;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `HRT_OFS_CTRL)
      begin
        lim_type_q <= reg_wdata_i[`HRT_CTRL_LIMTYPE];
        rpt_en_q   <= reg_wdata_i[`HRT_CTRL_RPTEN];
        tdm_q      <= reg_wdata_i[`HRT_CTRL_TDM];
        enable_q   <= reg_wdata_i[`HRT_CTRL_ENABLE];
      end
      else if (reg_addr_i == `HRT_OFS_CFG)
      begin
        lim_thr_q <= reg_wdata_i[`HRT_CFG_LIMTHR +: 4]; // see R22
        rot_q     <= reg_wdata_i[`HRT_CFG_ROT +: 4]; // see R4
        // Codes past the last step saturate to it
        if (reg_wdata_i[`HRT_CFG_MAXATN +: 4] > 4'(`HRT_MAXATN_CODE))
          max_sel_q <= 4'(`HRT_MAXATN_CODE); // see R16
        else
          max_sel_q <= reg_wdata_i[`HRT_CFG_MAXATN +: 4];
        if (reg_wdata_i[`HRT_CFG_HR +: 5] > 5'(`HRT_HR_MAX_CODE))
          hr_q <= 5'(`HRT_HR_MAX_CODE); // see R19
        else
          hr_q <= reg_wdata_i[`HRT_CFG_HR +: 5];
      end
      else if (reg_addr_i == `HRT_OFS_MAX_PEAK_OUTPUT)
        max_peak_output_q <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= '0;
    else if (!reg_rd_i)
      reg_rdata_o <= '0;
    else if (reg_addr_i == `HRT_OFS_CTRL)
      reg_rdata_o <= {28'h000_0000, enable_q, tdm_q, rpt_en_q, lim_type_q};
    else if (reg_addr_i == `HRT_OFS_CFG)
      reg_rdata_o <= {3'h0, hr_q, 4'h0, max_sel_q, 4'h0, rot_q,
                      4'h0, lim_thr_q};
    else if (reg_addr_i == `HRT_OFS_MAX_PEAK_OUTPUT)
      reg_rdata_o <= {16'h0000, max_peak_output_q};
    else if (reg_addr_i == `HRT_OFS_STATUS)
      reg_rdata_o <= {29'h0000_0000, act_q == ST_ACTIVE, end_flag_q,
                      begin_flag_q};
    else if (reg_addr_i == `HRT_OFS_ATTEN)
      reg_rdata_o <= {2'h0, report_data_o, att_q};
    else
      reg_rdata_o <= '0;
  end

  // ****************************************************************
  // Supply and level tracking
  // ****************************************************************
  logic [SAMPLE_W-1:0] mag;

  assign mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i)
                                    : SAMPLE_W'(sample_i);

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      vsup_q <= '0;
    else if (supply_valid_i)
      vsup_q <= 16'(supply_mv_i);
  end

  // Simple peak hold with exponential decay; real ballistics not modelled
  // Equal level holds the peak, so a steady tone sees a steady gain
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      peak_q <= '0;
    else if (sample_valid_i)
    begin
      if (mag >= peak_q)
        peak_q <= mag;
      else
        peak_q <= peak_q - (peak_q >> RLS_SHIFT);
    end
  end

  // ****************************************************************
  // Attenuation computation
  // ****************************************************************
  logic [47:0] target_peak_output_prod;
  logic [31:0] target_peak_output;
  int          target_peak_attenuation;
  int          a_in;
  int          lim_thr;
  int          lim_att;
  int          rp;
  int          drc_att;
  int          total;
  int          max_attenuation;

  // Target peak output = supply x (100% - headroom)
  assign target_peak_output_prod = 48'(vsup_q) * 48'(`HRT_HR_BASE + hr_q)
                   * 48'(`HRT_HR_DIV_K); // see R19
  assign target_peak_output      = target_peak_output_prod[47:16];
  assign a_in      = l2_to_db(log2_q6(32'(peak_q)) - FS_L2Q6);
  assign rp        = -(int'(rot_q) * `HRT_DB_UNIT); // see R4
  assign max_attenuation      = (int'(max_sel_q) + 1) * `HRT_DB_UNIT; // see R16

  always_comb
  begin
    target_peak_attenuation = l2_to_db(log2_q6(target_peak_output) - log2_q6(32'(max_peak_output_q)));
    if (target_peak_attenuation > 0)
      target_peak_attenuation = 0; // see R20
    // Fixed knee in level mode, tracking knee in distortion mode
    if (lim_type_q)
      lim_thr = -(int'(lim_thr_q) * `HRT_DB_UNIT); // see R1, R2, R3, R22
    else
      lim_thr = target_peak_attenuation; // see R21
    if (a_in > lim_thr)
      lim_att = a_in - lim_thr;
    else
      lim_att = 0;
    // Output spans threshold..target peak, so slope is target_peak_attenuation/rp
    if (rot_q != 4'h0 && a_in > rp)
      drc_att = ((a_in - rp) * (-target_peak_attenuation) * RECIP[rot_q])
                >>> 16; // see R5, R8
    else
      drc_att = 0; // see R7
    // Compressor first, limiter takes over when it bites harder
    if (drc_att > lim_att)
      total = drc_att; // see R12
    else
      total = lim_att;
    if (!enable_q)
      att_d = '0;
    else if (total > max_attenuation)
      att_d = atten_t'(max_attenuation); // see R17
    else
      att_d = atten_t'(total);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      att_q <= '0;
    else
      att_q <= att_d;
  end

  // ****************************************************************
  // Gain conversion and application
  // ****************************************************************
  logic [31:0] att_l2;
  logic [5:0]  frac;
  logic [15:0] gain_full;
  logic [15:0] gain_bend;

  assign att_l2    = (32'(att_q) * 32'(`HRT_DB_LOG_K)) >> 10;
  assign frac      = att_l2[5:0];
  // 2^-f as 1 - f/2 - 0.17 f(1-f); a bare line is 0.5 dB off mid-octave
  assign gain_bend = (16'(frac) * (16'h0040 - 16'(frac)) * 16'h000B)
                     >> 4;
  assign gain_full = (16'(`HRT_GAIN_ONE) - {3'h0, frac, 7'h00}
                      - gain_bend) >> att_l2[9:6];
  assign gain_d    = gain_full > 16'(`HRT_RPT_MAX)
                     ? 15'(`HRT_GAIN_ONE) : gain_full[14:0];

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      gain_q <= 15'(`HRT_GAIN_ONE);
    else
      gain_q <= gain_d;
  end

  hrt_gain_stage #(
    .SAMPLE_W (SAMPLE_W)
  ) u_gain (
    .sys_clk_i      (sys_clk_i),
    .resetn_i       (resetn_i),
    .sample_i       (sample_i),
    .sample_valid_i (sample_valid_i),
    .gain_i         (gain_q), // see R23
    .sample_o       (sample_o),
    .sample_valid_o (sample_valid_o)
  );

  // ****************************************************************
  // Activity tracking and flags
  // ****************************************************************
  logic set_begin;
  logic set_end;

  assign set_begin = (act_q == ST_IDLE) && (att_q != '0);
  assign set_end   = (act_q == ST_ACTIVE) && (att_q == '0);

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
      act_q <= ST_IDLE;
    else
    begin
      case (act_q)
        ST_IDLE:
          if (set_begin)
            act_q <= ST_ACTIVE;
        ST_ACTIVE:
          if (set_end)
            act_q <= ST_IDLE;
        default:
          act_q <= ST_IDLE;
      endcase
    end
  end

  // Only state edges set flags; the set beats a same-cycle clear
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      begin_flag_q <= 1'b0;
      end_flag_q   <= 1'b0;
    end
    else
    begin
      if (set_begin)
        begin_flag_q <= 1'b1; // see R13, R15
      else if (wr_status && reg_wdata_i[`HRT_ST_BEGIN])
        begin_flag_q <= 1'b0;
      if (set_end)
        end_flag_q <= 1'b1; // see R14, R15
      else if (wr_status && reg_wdata_i[`HRT_ST_END])
        end_flag_q <= 1'b0;
    end
  end

  assign attenuation_begin_irq_o = begin_flag_q;
  assign attenuation_end_irq_o   = end_flag_q;

  // ****************************************************************
  // Attenuation report
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      report_data_o  <= '0;
      report_valid_o <= 1'b0;
    end
    else if (rpt_en_q && tdm_q)
    begin
      // Full scale 16383 means 0 dB
      report_data_o  <= gain_q > 15'(`HRT_RPT_MAX) ? `HRT_RPT_W'(`HRT_RPT_MAX)
                        : gain_q[13:0]; // see R18
      report_valid_o <= 1'b1;
    end
    else
    begin
      report_data_o  <= '0;
      report_valid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_att_clamp: // see R17
    assert property ($stable(max_sel_q) |-> int'(att_q) <= max_attenuation)
      else $error("attenuation above programmed maximum");
  chk_no_gain: // see R20
    assert property (att_q == '0 |=> gain_q == 15'(`HRT_GAIN_ONE))
      else $error("unity gain not restored at zero attenuation");
  chk_begin_flag: // see R13
    assert property (set_begin |=> begin_flag_q && act_q == ST_ACTIVE)
      else $error("begin flag missing");
  chk_end_flag: // see R14
    assert property (set_end |=> end_flag_q && act_q == ST_IDLE)
      else $error("end flag missing");
  chk_quiet_adjust: // see R15
    assert property ((act_q == ST_ACTIVE && att_q != '0)
                     |=> !$rose(begin_flag_q) && !$rose(end_flag_q))
      else $error("flag raised while adjusting");
  chk_below_rp: // see R7
    assert property (enable_q && rot_q != 4'h0 && lim_att == 0
                     && a_in <= rp |=> att_q == '0)
      else $error("compression below rotation point");
  chk_sll_fixed: // see R2
    assert property ((lim_type_q && rot_q == 4'h0 && $stable(peak_q)
                      && $stable(lim_type_q) && $stable(rot_q)
                      && $stable(lim_thr_q) && $stable(max_sel_q)
                      && $stable(enable_q)) |=> $stable(att_q))
      else $error("level limiter moved with supply");
  chk_report_off: // see R18
    assert property (!(rpt_en_q && tdm_q)
                     |=> !report_valid_o && report_data_o == '0)
      else $error("report active while disabled");
  chk_unity_pass: // see R23
    assert property ((gain_q == 15'(`HRT_GAIN_ONE) && sample_valid_i)
                     |=> sample_valid_o && sample_o == $past(sample_i))
      else $error("sample altered at unity gain");

endmodule

/* test/audio_supply_source.sv */
// Sample stream and supply measurement source facing the limiter
`timescale 1ns/10ps
module audio_supply_source #(
  parameter int SAMPLE_W = 24
)(
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  resetn_i,
  // Bench control
  input  wire logic [SAMPLE_W-1:0]   level_i,
  input  wire logic [15:0]           supply_set_i,
  // Toward the limiter
  output logic signed [SAMPLE_W-1:0] sample_o,
  output logic                       sample_valid_o,
  output logic [15:0]                supply_mv_o,
  output logic                       supply_valid_o
);
  logic [3:0] tick_q = 4'h0;
  logic       sign_q = 1'b0;

  initial
  begin
    sample_o       = '0;
    sample_valid_o = 1'b0;
    supply_mv_o    = 16'h0000;
    supply_valid_o = 1'b0;
  end

  // ********************
  // Stream and converter
  // ********************
  always @(posedge sys_clk_i)
  begin
    tick_q         <= tick_q + 4'h1;
    sample_valid_o <= resetn_i & tick_q[0];
    if (tick_q[0])
    begin
      sign_q   <= ~sign_q;
      sample_o <= sign_q ? -$signed(level_i) : $signed(level_i);
    end
    else
      sample_o <= ~sample_o;
    // Lines carry no stale value between conversions
    supply_valid_o <= resetn_i & (tick_q == 4'hF);
    supply_mv_o    <= (tick_q == 4'hF) ? supply_set_i : ~supply_set_i;
  end
endmodule

/* test/headroom_tracking_gain_limiter_tb.sv */
// Self-checking bench for the headroom tracking gain limiter
`timescale 1ns/10ps
`include "hrt_cfg.svh"
module headroom_tracking_gain_limiter_tb;
  localparam int SW = 24;
  localparam int FS = 8388607;

  logic                 sys_clk   = 1'b0;
  logic                 resetn    = 1'b0;
  logic [7:0]           reg_addr  = 8'h00;
  logic [31:0]          reg_wdata = 32'h0000_0000;
  logic                 reg_wr    = 1'b0;
  logic                 reg_rd    = 1'b0;
  logic [31:0]          reg_rdata;
  logic [SW-1:0]        level     = '0;
  logic [15:0]          supply    = 16'h353E;
  logic signed [SW-1:0] smp_in;
  logic signed [SW-1:0] smp_out;
  logic                 smp_vin;
  logic                 smp_vout;
  logic [15:0]          sup_mv;
  logic                 sup_valid;
  logic                 beg_irq;
  logic                 end_irq;
  logic [13:0]          rpt_data;
  logic                 rpt_valid;
  int                   miscompares = 0;
  int                   checks_done = 0;
  logic                 chk_smp     = 1'b0;
  real                  exp_gain    = 1.0;
  real                  tol         = 0.0;
  int                   q_in[$];

  headroom_tracking_gain_limiter #(.SAMPLE_W(SW), .RLS_SHIFT(3)) dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .supply_mv_i(sup_mv),
    .supply_valid_i(sup_valid), .sample_i(smp_in),
    .sample_valid_i(smp_vin), .sample_o(smp_out),
    .sample_valid_o(smp_vout), .attenuation_begin_irq_o(beg_irq),
    .attenuation_end_irq_o(end_irq), .report_data_o(rpt_data),
    .report_valid_o(rpt_valid));

  audio_supply_source #(.SAMPLE_W(SW)) src (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .level_i(level),
    .supply_set_i(supply), .sample_o(smp_in), .sample_valid_o(smp_vin),
    .supply_mv_o(sup_mv), .supply_valid_o(sup_valid));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Attenuation in 1/64 dB; combination by max, clamp at the maximum
  function automatic real model_att(input int lim, thr, rot, maxc, hr,
                                    input int sup, lvl);
    real in_db;
    real target_peak_attenuation;
    real a;
    real ac;
    in_db = 20.0 * $log10(real'(lvl) / FS);
    target_peak_attenuation  = 20.0 * $log10(sup * (0.8 + 0.025 * hr) / 13630.0);
    if (target_peak_attenuation > 0.0)
      target_peak_attenuation = 0.0;
    a  = (lim != 0) ? in_db + thr : in_db - target_peak_attenuation;
    ac = (rot != 0 && in_db > -rot) ? (in_db + rot) * (-target_peak_attenuation) / rot : 0.0;
    if (ac > a)
      a = ac;
    if (a < 0.0)
      a = 0.0;
    if (a > maxc + 1)
      a = maxc + 1;
    return a * 64.0;
  endfunction

  task automatic run_case(input int lim, thr, rot, maxc, hr, sup, lvl);
    logic [31:0] d;
    real         m;
    m = model_att(lim, thr, rot, maxc, hr, sup, lvl);
    supply <= sup[15:0];
    level  <= lvl[SW-1:0];
    reg_write(`HRT_OFS_CTRL, 32'h0000_0008 | 32'(lim));
    reg_write(`HRT_OFS_CFG, {3'b000, hr[4:0], 4'h0, maxc[3:0], 4'h0,
                             rot[3:0], 4'h0, thr[3:0]});
    repeat (400) @(posedge sys_clk);
    exp_gain = $pow(10.0, -m / 1280.0);
    tol      = 0.08;
    chk_smp  = 1'b1;
    repeat (40) @(posedge sys_clk);
    chk_smp  = 1'b0;
    reg_read(`HRT_OFS_ATTEN, d);
    if (m >= (maxc + 1) * 64.0)
      check(d[15:0] === 16'((maxc + 1) * 64), "clamped attenuation");
    else
      check(!$isunknown(d) && (real'(d[15:0]) - m) ** 2 <= 2304.0,
            "attenuation level");
  endtask

  // Model queue of samples against the design output
  always @(posedge sys_clk)
  begin
    int  e;
    real dv;
    if (smp_vin)
      q_in.push_back(int'(smp_in));
    if (smp_vout && q_in.size() > 0)
    begin
      e  = q_in.pop_front();
      dv = real'(smp_out) - real'(e) * exp_gain;
      if (chk_smp)
        check(!$isunknown(smp_out) && dv * dv <= tol * tol *
              (real'(e) * real'(e) + 4096.0), "sample gain");
    end
  end

  initial
  begin
    #400000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    static logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
    static logic [31:0] rv [5] = '{32'h0000_0000, 32'h0805_0000,
                                   32'h0000_353E,
                            32'h0000_0000, 32'h0000_0000};
    logic [31:0] d;
    real         m;
    void'($urandom(32'hf4e3_0690));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    reg_write(8'h14, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++)
    begin
      reg_read(ra[i], d);
      check(d === rv[i], "register default");
    end
    chk_smp = 1'b1;
    repeat (200)
    begin
      @(posedge sys_clk);
      level <= SW'($urandom) & 24'h7F_FFFF;
    end
    chk_smp = 1'b0;
    reg_read(`HRT_OFS_ATTEN, d);
    check(d[15:0] === 16'h0000 && beg_irq === 1'b0, "idle path");
    reg_write(`HRT_OFS_CFG, 32'h1F0F_0000);
    reg_read(`HRT_OFS_CFG, d);
    check(d[28:16] === 13'h100E, "code saturation");
    run_case(0, 0, 0, 14, 0, 13630, FS);
    run_case(0, 0, 0, 14, 8, 13630, FS);
    run_case(0, 0, 0, 14, 16, 13630, FS);
    run_case(0, 0, 0, 0, 8, 6815, FS);
    run_case(0, 0, 0, 2, 8, 6815, FS);
    run_case(0, 0, 0, 14, 8, 6815, FS);
    run_case(1, 4, 0, 14, 8, 20000, FS);
    run_case(1, 4, 0, 14, 8, 15000, FS);
    run_case(1, 4, 0, 14, 8, 9000, FS);
    // Rotation at -6 dBFS keeps the threshold above a low rail
    run_case(1, 0, 6, 14, 8, 6815, FS / 4);
    // Idle here; clear so only the next begin and no end is seen
    reg_write(`HRT_OFS_STATUS, 32'h0000_0003);
    run_case(1, 0, 6, 14, 8, 6815, FS);
    run_case(1, 0, 6, 14, 8, 9636, FS);
    run_case(1, 0, 15, 14, 8, 6815, FS / 4);
    run_case(1, 2, 12, 14, 8, 11000, FS);
    run_case(1, 2, 12, 14, 8, 11000, FS / 2);
    check(beg_irq === 1'b1 && end_irq === 1'b0, "begin flag");
    run_case(0, 0, 0, 14, 8, 6815, FS * 3 / 4);
    reg_write(`HRT_OFS_STATUS, 32'h0000_0003);
    level <= FS[SW-1:0];
    repeat (300) @(posedge sys_clk);
    check(beg_irq === 1'b0 && end_irq === 1'b0, "flag on adjust");
    m = model_att(0, 0, 0, 14, 8, 6815, FS);
    reg_write(`HRT_OFS_CTRL, 32'h0000_000E);
    repeat (4) @(posedge sys_clk);
    check(rpt_valid === 1'b1 && (real'(rpt_data) - 16383.0 *
          $pow(10.0, -m / 1280.0)) ** 2 <= 360000.0, "report");
    reg_write(`HRT_OFS_CTRL, 32'h0000_000C);
    repeat (4) @(posedge sys_clk);
    check(rpt_valid === 1'b0 && rpt_data === 14'h0000, "no report");
    level <= '0;
    repeat (600) @(posedge sys_clk);
    reg_read(`HRT_OFS_STATUS, d);
    check(end_irq === 1'b1 && beg_irq === 1'b0 && d[2] === 1'b0,
          "end flag");
    level <= FS[SW-1:0];
    repeat (300) @(posedge sys_clk);
    check(beg_irq === 1'b1, "begin again");
    print_verdict();
  end
endmodule
